// ==== verilog/pbm_port_b_override.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbm_port_b_override #(
  parameter int unsigned PORT_WIDTH = pbm_pkg::PORT_WIDTH
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [PORT_WIDTH-1:0] port_b_dir_i,
  input wire logic [PORT_WIDTH-1:0] port_b_out_i,
  input wire logic global_pullup_disable_i,
  input wire logic mcu_input_enable_i,
  input wire logic [PORT_WIDTH-1:0] pad_in_i,
  output logic [PORT_WIDTH-1:0] pad_out_o,
  output logic [PORT_WIDTH-1:0] pad_oe_o,
  output logic [PORT_WIDTH-1:0] pad_pullup_o,
  input wire logic serial_periph_on_i,
  input wire logic master_role_select_i,
  input wire logic spi_clock_out_i,
  input wire logic spi_slave_data_out_i,
  input wire logic spi_master_data_out_i,
  output logic spi_clock_in_o,
  output logic spi_master_data_in_o,
  output logic spi_slave_data_in_o,
  output logic spi_select_n_o,
  output logic spi_slave_active_o,
  input wire logic timer0_compare_output_i,
  input wire logic timer0_compare_enable_i,
  input wire logic ext_irq2_enable_i,
  output logic ext_irq2_input_o,
  output logic timer0_count_input_o,
  output logic timer1_count_input_o,
  input wire logic usart_sync_select_i,
  input wire logic usart_ext_clock_out_i,
  output logic usart_ext_clock_in_o,
  input wire logic jtag_enable_i,
  output logic [2:0] next_port_jtag_pullup_o,
  input wire logic timer2_async_select_i,
  output logic next_port_pin7_detach_o
);
  // pin map is fixed, so only the documented width can be served
  generate
    if (PORT_WIDTH != pbm_pkg::PORT_WIDTH) begin : g_bad_width
      $error("pbm_port_b_override supports only an eight pin port");
    end
  endgenerate

  logic [PORT_WIDTH-1:0] pullup_override_enable;
  logic [PORT_WIDTH-1:0] pullup_override_value;
  logic [PORT_WIDTH-1:0] direction_override_enable;
  logic [PORT_WIDTH-1:0] direction_override_value;
  logic [PORT_WIDTH-1:0] value_override_enable;
  logic [PORT_WIDTH-1:0] value_override_value;
  logic [PORT_WIDTH-1:0] input_gate_override_enable;
  logic [PORT_WIDTH-1:0] input_gate_override_value;
  logic [PORT_WIDTH-1:0] pad_sync;
  logic [PORT_WIDTH-1:0] alt_input_tap;
  logic [PORT_WIDTH-1:0] next_out;
  logic [PORT_WIDTH-1:0] next_oe;
  logic [PORT_WIDTH-1:0] next_pullup;
  logic spi_master;
  logic spi_slave;

  assign spi_master = serial_periph_on_i & master_role_select_i;
  assign spi_slave = serial_periph_on_i & ~master_role_select_i;

  always_comb begin
    pullup_override_enable = '0;
    pullup_override_value = '0;
    direction_override_enable = '0;
    direction_override_value = '0;
    value_override_enable = '0;
    value_override_value = '0;
    input_gate_override_enable = '0;
    input_gate_override_value = '0;
    direction_override_enable[pbm_pkg::PIN_SCK] = spi_slave;
    direction_override_enable[pbm_pkg::PIN_MISO] = spi_master;
    direction_override_enable[pbm_pkg::PIN_MOSI] = spi_slave;
    direction_override_enable[pbm_pkg::PIN_SEL] = spi_slave;
    direction_override_value[pbm_pkg::PIN_SCK] = pbm_pkg::OVR_ZERO;
    direction_override_value[pbm_pkg::PIN_MISO] = pbm_pkg::OVR_ZERO;
    direction_override_value[pbm_pkg::PIN_MOSI] = pbm_pkg::OVR_ZERO;
    direction_override_value[pbm_pkg::PIN_SEL] = pbm_pkg::OVR_ZERO;
    pullup_override_enable[pbm_pkg::PIN_SCK] = spi_slave;
    pullup_override_enable[pbm_pkg::PIN_MISO] = spi_master;
    pullup_override_enable[pbm_pkg::PIN_MOSI] = spi_slave;
    pullup_override_enable[pbm_pkg::PIN_SEL] = spi_slave;
    // port bit gated by global disable
    pullup_override_value[pbm_pkg::PIN_SCK] =
      port_b_out_i[pbm_pkg::PIN_SCK] & ~global_pullup_disable_i;
    pullup_override_value[pbm_pkg::PIN_MISO] =
      port_b_out_i[pbm_pkg::PIN_MISO] & ~global_pullup_disable_i;
    pullup_override_value[pbm_pkg::PIN_MOSI] =
      port_b_out_i[pbm_pkg::PIN_MOSI] & ~global_pullup_disable_i;
    pullup_override_value[pbm_pkg::PIN_SEL] =
      port_b_out_i[pbm_pkg::PIN_SEL] & ~global_pullup_disable_i;
    value_override_enable[pbm_pkg::PIN_SCK] = spi_master;
    value_override_value[pbm_pkg::PIN_SCK] = spi_clock_out_i;
    value_override_enable[pbm_pkg::PIN_MISO] = spi_slave;
    value_override_value[pbm_pkg::PIN_MISO] = spi_slave_data_out_i;
    value_override_enable[pbm_pkg::PIN_MOSI] = spi_master;
    value_override_value[pbm_pkg::PIN_MOSI] = spi_master_data_out_i;
    value_override_enable[pbm_pkg::PIN_CMP0] = timer0_compare_enable_i;
    value_override_value[pbm_pkg::PIN_CMP0] = timer0_compare_output_i;
    input_gate_override_enable[pbm_pkg::PIN_IRQ2] = ext_irq2_enable_i;
    input_gate_override_value[pbm_pkg::PIN_IRQ2] = pbm_pkg::OVR_ONE;
    value_override_enable[pbm_pkg::PIN_CNT0] = usart_sync_select_i;
    value_override_value[pbm_pkg::PIN_CNT0] = usart_ext_clock_out_i;
  end

  pbm_sync3 #(
    .WIDTH(PORT_WIDTH)
  ) u_pad_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pad_in_i),
    .sync_o(pad_sync)
  );

  genvar p;
  generate
    for (p = 0; p < PORT_WIDTH; p++) begin : g_pin
      assign next_pullup[p] = pullup_override_enable[p] ? pullup_override_value[p] :
        (~port_b_dir_i[p] & port_b_out_i[p] & ~global_pullup_disable_i);
      assign next_oe[p] = direction_override_enable[p] ? direction_override_value[p] :
        port_b_dir_i[p];
      assign next_out[p] = value_override_enable[p] ? value_override_value[p] :
        port_b_out_i[p];
      assign alt_input_tap[p] = pad_sync[p] & (input_gate_override_enable[p] ?
        input_gate_override_value[p] : mcu_input_enable_i);
    end
  endgenerate

  // registered pad drive costs one cycle but keeps pad outputs glitch free
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pad_out_o <= pbm_pkg::PORT_RESET;
      pad_oe_o <= pbm_pkg::PORT_RESET;
      pad_pullup_o <= pbm_pkg::PORT_RESET;
    end else begin
      pad_out_o <= next_out;
      pad_oe_o <= next_oe;
      pad_pullup_o <= next_pullup;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      spi_clock_in_o <= 1'b0;
      spi_master_data_in_o <= 1'b0;
      spi_slave_data_in_o <= 1'b0;
      spi_select_n_o <= 1'b1;
      spi_slave_active_o <= 1'b0;
    end else begin
      spi_clock_in_o <= alt_input_tap[pbm_pkg::PIN_SCK];
      spi_master_data_in_o <= alt_input_tap[pbm_pkg::PIN_MISO];
      spi_slave_data_in_o <= alt_input_tap[pbm_pkg::PIN_MOSI];
      spi_select_n_o <= alt_input_tap[pbm_pkg::PIN_SEL];
      spi_slave_active_o <= spi_slave & ~alt_input_tap[pbm_pkg::PIN_SEL];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ext_irq2_input_o <= 1'b0;
      timer0_count_input_o <= 1'b0;
      timer1_count_input_o <= 1'b0;
      usart_ext_clock_in_o <= 1'b0;
    end else begin
      ext_irq2_input_o <= alt_input_tap[pbm_pkg::PIN_IRQ2];
      timer1_count_input_o <= alt_input_tap[pbm_pkg::PIN_CNT1];
      timer0_count_input_o <= alt_input_tap[pbm_pkg::PIN_CNT0];
      usart_ext_clock_in_o <= usart_sync_select_i & alt_input_tap[pbm_pkg::PIN_CNT0];
    end
  end

  // no reset term here, so the pull-ups survive a reset
  always_ff @(posedge core_clk_i) begin
    next_port_jtag_pullup_o <= {3{jtag_enable_i}};
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      next_port_pin7_detach_o <= 1'b0;
    end else begin
      next_port_pin7_detach_o <= timer2_async_select_i;
    end
  end
endmodule
`default_nettype wire

// ==== pkg/pbm_pkg.sv ====
package pbm_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned PIN_SCK = 7;
  localparam int unsigned PIN_MISO = 6;
  localparam int unsigned PIN_MOSI = 5;
  localparam int unsigned PIN_SEL = 4;
  localparam int unsigned PIN_CMP0 = 3;
  localparam int unsigned PIN_IRQ2 = 2;
  localparam int unsigned PIN_CNT1 = 1;
  localparam int unsigned PIN_CNT0 = 0;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic OVR_ZERO = 1'b0;
  localparam logic OVR_ONE = 1'b1;
endpackage

// ==== verilog/pbm_sync3.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbm_sync3 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 is read by stage2 only; metastability stays contained
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      // a change counts once two later stages agree
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          sync_o[b] <= 1'b0;
        end else if (stage2[b] == stage3[b]) begin
          sync_o[b] <= stage3[b];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== verif/pbm_port_b_override_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbm_port_b_override_sva (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] port_b_dir_i,
  input wire logic [7:0] port_b_out_i,
  input wire logic global_pullup_disable_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_pullup_o,
  input wire logic serial_periph_on_i,
  input wire logic master_role_select_i,
  input wire logic spi_clock_out_i,
  input wire logic spi_slave_active_o,
  input wire logic timer0_compare_output_i,
  input wire logic timer0_compare_enable_i,
  input wire logic usart_sync_select_i,
  input wire logic usart_ext_clock_out_i,
  input wire logic jtag_enable_i,
  input wire logic [2:0] next_port_jtag_pullup_o,
  input wire logic timer2_async_select_i,
  input wire logic next_port_pin7_detach_o
);
  wire logic mst = serial_periph_on_i & master_role_select_i;
  wire logic slv = serial_periph_on_i & ~master_role_select_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  logic rst_d;
  // outputs still show reset values one edge after release, so hold checks off
  always_ff @(posedge core_clk_i) begin
    rst_d <= sys_rst_i;
  end
  default disable iff (sys_rst_i || rst_d);
  AST_MISO_IN: assert property (mst |=> !pad_oe_o[6])
    else $error("data in pin driven in master role");
  AST_SLAVE_IN: assert property (slv |=> (pad_oe_o & 8'hB0) == 8'h00)
    else $error("slave owned pin driven");
  AST_DIR_FOLLOW: assert property (!serial_periph_on_i |=>
    pad_oe_o[7:4] == $past(port_b_dir_i[7:4]))
    else $error("driver enable not following direction bits");
  AST_PULLUP: assert property (slv |=>
    pad_pullup_o[5] == $past(port_b_out_i[5] & ~global_pullup_disable_i))
    else $error("forced input pin lost its pull-up control");
  AST_SCK_VAL: assert property (mst && port_b_dir_i[7] |=>
    pad_out_o[7] == $past(spi_clock_out_i))
    else $error("clock pin value not taken from spi");
  AST_CMP_VAL: assert property (timer0_compare_enable_i && port_b_dir_i[3] |=>
    pad_oe_o[3] && pad_out_o[3] == $past(timer0_compare_output_i))
    else $error("compare output missing on pin 3");
  AST_UCLK_VAL: assert property (usart_sync_select_i && port_b_dir_i[0] |=>
    pad_out_o[0] == $past(usart_ext_clock_out_i))
    else $error("usart clock missing on pin 0");
  // reset must not drop these pull-ups, so no disable here
  AST_JTAG_PU: assert property (@(posedge core_clk_i) disable iff (1'b0)
    jtag_enable_i |=> next_port_jtag_pullup_o == 3'h7)
    else $error("jtag pull-ups dropped");
  AST_DETACH: assert property (timer2_async_select_i |=> next_port_pin7_detach_o)
    else $error("oscillator pin not detached");
  cover property (slv ##1 spi_slave_active_o);
  cover property (mst && port_b_dir_i[7]);
  cover property (timer0_compare_enable_i && port_b_dir_i[3]);
endmodule
bind pbm_port_b_override pbm_port_b_override_sva chk_i (.*);
`default_nettype wire

// ==== verif/pbm_pad_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbm_pad_model (
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_level_i,
  output logic [7:0] pad_level_o
);
  // outside world drives undriven pins, select low addresses us
  assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule
`default_nettype wire

// ==== verif/pbm_port_b_override_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbm_port_b_override_tb;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1;
  logic [7:0] port_b_dir_i = 8'h00, port_b_out_i = 8'h00, ext = 8'h00, pad_in_i;
  logic [7:0] pad_out_o, pad_oe_o, pad_pullup_o, tp;
  logic [2:0] next_port_jtag_pullup_o;
  logic global_pullup_disable_i = 1'b0, mcu_input_enable_i = 1'b1;
  logic serial_periph_on_i = 1'b0;
  logic master_role_select_i = 1'b0, spi_clock_out_i = 1'b0, spi_slave_data_out_i = 1'b0;
  logic spi_master_data_out_i = 1'b0, timer0_compare_output_i = 1'b0;
  logic timer0_compare_enable_i = 1'b0;
  logic ext_irq2_enable_i = 1'b0, usart_sync_select_i = 1'b0, usart_ext_clock_out_i = 1'b0;
  logic jtag_enable_i = 1'b0, timer2_async_select_i = 1'b0;
  logic spi_clock_in_o, spi_master_data_in_o, spi_slave_data_in_o;
  logic spi_select_n_o, spi_slave_active_o;
  logic ext_irq2_input_o, timer0_count_input_o, timer1_count_input_o, usart_ext_clock_in_o;
  logic next_port_pin7_detach_o;
  logic [63:0] r;
  int failures = 0, compares = 0, cyc = 0;
  pbm_port_b_override uut (.*);
  pbm_pad_model pads (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_level_i(ext),
    .pad_level_o(pad_in_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] f_ovs();
    if (!serial_periph_on_i) return 8'h00;
    return master_role_select_i ? 8'h40 : 8'hB0;
  endfunction
  function automatic logic [7:0] f_val();
    logic [7:0] v;
    v = port_b_out_i;
    if (f_ovs() == 8'h40) {v[7], v[5]} = {spi_clock_out_i, spi_master_data_out_i};
    if (f_ovs() == 8'hB0) v[6] = spi_slave_data_out_i;
    if (timer0_compare_enable_i) v[3] = timer0_compare_output_i;
    if (usart_sync_select_i) v[0] = usart_ext_clock_out_i;
    return v;
  endfunction
  task check_all();
    logic [7:0] eo, pu, p, g;
    logic m;
    eo = port_b_dir_i & ~f_ovs();
    pu = port_b_out_i & {8{~global_pullup_disable_i}};
    p = (eo & f_val()) | (~eo & ext);
    m = mcu_input_enable_i;
    // pins 4 and 3 have no tap in the compared vector
    g = {{5{m}}, m | ext_irq2_enable_i, m, m} & 8'hE7;
    chk(pad_oe_o, eo);
    chk(pad_out_o & eo, f_val() & eo);
    chk(pad_pullup_o, pu & (f_ovs() | ~port_b_dir_i));
    tp = {spi_clock_in_o, spi_master_data_in_o, spi_slave_data_in_o, 1'b0, 1'b0,
      ext_irq2_input_o, timer1_count_input_o, timer0_count_input_o};
    chk(tp, p & g);
    chk({7'h00, usart_ext_clock_in_o}, {7'h00, p[0] & m & usart_sync_select_i});
    if (m) chk({6'h00, spi_select_n_o, spi_slave_active_o},
      {6'h00, p[4], f_ovs() == 8'hB0 && !p[4]});
  endtask
  initial begin
    void'($urandom(32'h8012));
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk_i);
      r = {$urandom, $urandom};
      {port_b_dir_i, port_b_out_i, ext} <= r[23:0];
      {global_pullup_disable_i, serial_periph_on_i, master_role_select_i, spi_clock_out_i,
        spi_slave_data_out_i, spi_master_data_out_i, timer0_compare_output_i,
        timer0_compare_enable_i} <= r[31:24];
      {ext_irq2_enable_i, usart_sync_select_i, usart_ext_clock_out_i, jtag_enable_i,
        timer2_async_select_i} <= r[36:32];
      mcu_input_enable_i <= (i < 20) ? 1'b0 : r[37] | r[38];
      repeat (8) @(posedge core_clk_i);
      #1 check_all();
    end
    // reset in mid-run with jtag on
    @(posedge core_clk_i);
    {jtag_enable_i, timer2_async_select_i, sys_rst_i} <= 3'h7;
    repeat (3) @(posedge core_clk_i);
    #1 chk({3'h0, next_port_jtag_pullup_o, next_port_pin7_detach_o, spi_select_n_o}, 8'h1D);
    chk(pad_oe_o | pad_pullup_o, 8'h00);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1 chk({7'h00, next_port_pin7_detach_o}, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
